// file: rtl/supply_supervisor_regulator_modes.v
`timescale 1ns/1ps
`include "supply_supervisor_map.vh"
module supply_supervisor_regulator_modes #(
  parameter HAS_SUPERVISOR_STRAP = 1,
  parameter HAS_BYPASS_STRAP = 1
) (
  input wire mclk_in,
  input wire rst_in,
  input wire supervisor_enable_strap_in,
  input wire bypass_strap_in,
  input wire ext_reset_n_in,
  input wire above_por_1v8_in,
  input wire above_1v7_in,
  input wire above_2v1_in,
  input wire bor_above_level1_in,
  input wire bor_above_level2_in,
  input wire bor_above_level3_in,
  input wire opt_valid_in,
  input wire [1:0] opt_bor_sel_in,
  input wire pvd_above_in,
  input wire pvd_enable_in,
  input wire pvd_rise_en_in,
  input wire pvd_fall_en_in,
  input wire [1:0] op_mode_in,
  input wire overdrive_req_in,
  input wire underdrive_req_in,
  input wire lp_regulator_req_in,
  output reg device_reset_out,
  output reg opt_loading_out,
  output reg [1:0] bor_level_out,
  output reg supervisor_active_out,
  output reg programmable_voltage_detector_on_out,
  output wire pvd_event_out,
  output reg battery_backup_available_out,
  output reg regulator_enabled_out,
  output reg [2:0] regulator_cfg_out,
  output reg low_power_regulator_sel_out,
  output reg request_refused_out
);
  localparam ST_POR = 4'h1;
  localparam ST_LOAD = 4'h2;
  localparam ST_RUN = 4'h4;
  localparam ST_EXTRST = 4'h8;
  localparam integer LOAD_CYC_INT = `OPT_LOAD_CYCLES;
  localparam [7:0] LOAD_CYC = LOAD_CYC_INT[7:0];

  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [7:0] load_cnt_r;
  reg [1:0] bor_sel_r;
  reg [1:0] prev_mode_r;
  reg od_r;
  reg ud_r;
  reg lp_r;
  wire sup_en;
  wire reg_en;
  wire bor_low;
  wire od_allowed;

  assign sup_en = HAS_SUPERVISOR_STRAP ? supervisor_enable_strap_in : 1'b1;
  assign reg_en = HAS_BYPASS_STRAP ? !bypass_strap_in : 1'b1;
  assign od_allowed = above_2v1_in || !above_1v7_in ? above_2v1_in : 1'b0;

  // Brownout comparison against the loaded threshold
  assign bor_low = (bor_sel_r == `BOR_SEL_LEVEL1 && !bor_above_level1_in) ||
                   (bor_sel_r == `BOR_SEL_LEVEL2 && !bor_above_level2_in) ||
                   (bor_sel_r == `BOR_SEL_LEVEL3 && !bor_above_level3_in);

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_POR: begin
        if (!sup_en) state_nxt = ST_EXTRST;
        else if (above_por_1v8_in) state_nxt = ST_LOAD;
      end
      ST_LOAD: begin
        if (!sup_en) state_nxt = ST_EXTRST;
        else if (!above_por_1v8_in) state_nxt = ST_POR;
        else if (opt_valid_in && load_cnt_r >= LOAD_CYC) state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (!sup_en) state_nxt = ST_EXTRST;
        else if (!above_por_1v8_in) state_nxt = ST_POR;
      end
      ST_EXTRST: begin
        if (sup_en) state_nxt = ST_POR;
      end
      default: state_nxt = ST_POR;
    endcase
  end

  always @(posedge mclk_in) begin
    if (rst_in) begin
      state_r <= ST_POR;
      load_cnt_r <= 8'h00;
      bor_sel_r <= `BOR_SEL_RESET;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_LOAD && load_cnt_r != 8'hFF) load_cnt_r <= load_cnt_r + 8'h01;
      else if (state_r != ST_LOAD) load_cnt_r <= 8'h00;
      if (state_r == ST_LOAD && opt_valid_in) bor_sel_r <= opt_bor_sel_in;
      else if (state_r == ST_EXTRST) bor_sel_r <= `BOR_SEL_OFF;
    end
  end

  always @(posedge mclk_in) begin
    if (rst_in) begin
      device_reset_out <= 1'b1;
      opt_loading_out <= 1'b0;
      bor_level_out <= `BOR_SEL_RESET;
      supervisor_active_out <= 1'b0;
      programmable_voltage_detector_on_out <= 1'b0;
      battery_backup_available_out <= 1'b0;
      regulator_enabled_out <= 1'b0;
    end else begin
      // Strap low hands reset to the external supervisor at once, not a cycle later
      if (state_r == ST_EXTRST || !sup_en)
        device_reset_out <= !ext_reset_n_in;
      else
        device_reset_out <= (state_r != ST_RUN) || !above_por_1v8_in || bor_low;
      opt_loading_out <= (state_r == ST_LOAD);
      bor_level_out <= bor_sel_r;
      supervisor_active_out <= sup_en;
      programmable_voltage_detector_on_out <= pvd_enable_in && sup_en && state_r == ST_RUN;
      battery_backup_available_out <= sup_en;
      regulator_enabled_out <= reg_en;
    end
  end

  edge_event_detector u_pvd (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .enable_in(programmable_voltage_detector_on_out),
    .level_in(pvd_above_in),
    .rise_en_in(pvd_rise_en_in),
    .fall_en_in(pvd_fall_en_in),
    .event_out(pvd_event_out)
  );

  // Regulator configuration follows the operating mode
  always @(posedge mclk_in) begin
    if (rst_in) begin
      prev_mode_r <= `OPMODE_RUN;
      od_r <= 1'b0;
      ud_r <= 1'b0;
      lp_r <= 1'b0;
      regulator_cfg_out <= `REG_CFG_NORMAL;
      low_power_regulator_sel_out <= 1'b0;
      request_refused_out <= 1'b0;
    end else begin
      prev_mode_r <= op_mode_in;
      request_refused_out <= 1'b0;
      if (!reg_en) begin
        od_r <= 1'b0;
        ud_r <= 1'b0;
        lp_r <= 1'b0;
        regulator_cfg_out <= `REG_CFG_OFF;
        low_power_regulator_sel_out <= 1'b0;
      end else begin
        case (op_mode_in)
          `OPMODE_RUN, `OPMODE_SLEEP: begin
            lp_r <= 1'b0;
            ud_r <= 1'b0;
            low_power_regulator_sel_out <= 1'b0;
            if (underdrive_req_in || lp_regulator_req_in) request_refused_out <= 1'b1;
            if (overdrive_req_in && od_allowed) begin
              od_r <= 1'b1;
              regulator_cfg_out <= `REG_CFG_OVERDRIVE;
            end else if (overdrive_req_in) begin
              request_refused_out <= 1'b1;
              regulator_cfg_out <= od_r && od_allowed ? `REG_CFG_OVERDRIVE : `REG_CFG_NORMAL;
              od_r <= od_r && od_allowed;
            end else begin
              od_r <= 1'b0;
              regulator_cfg_out <= `REG_CFG_NORMAL;
            end
          end
          `OPMODE_STOP: begin
            od_r <= 1'b0;
            if (overdrive_req_in) request_refused_out <= 1'b1;
            if (prev_mode_r != `OPMODE_STOP) begin
              lp_r <= lp_regulator_req_in;
              ud_r <= underdrive_req_in;
              low_power_regulator_sel_out <= lp_regulator_req_in;
              regulator_cfg_out <= underdrive_req_in ? `REG_CFG_UNDERDRIVE : `REG_CFG_NORMAL;
            end else begin
              low_power_regulator_sel_out <= lp_r;
              regulator_cfg_out <= ud_r ? `REG_CFG_UNDERDRIVE : `REG_CFG_NORMAL;
            end
          end
          `OPMODE_STANDBY: begin
            od_r <= 1'b0;
            ud_r <= 1'b0;
            lp_r <= 1'b0;
            low_power_regulator_sel_out <= 1'b0;
            if (overdrive_req_in || underdrive_req_in || lp_regulator_req_in)
              request_refused_out <= 1'b1;
            regulator_cfg_out <= `REG_CFG_POWERDOWN;
          end
          default: regulator_cfg_out <= `REG_CFG_NORMAL;
        endcase
      end
    end
  end
endmodule

// file: rtl/supply_supervisor_map.vh
`ifndef SUPPLY_SUPERVISOR_MAP_VH
`define SUPPLY_SUPERVISOR_MAP_VH
// Operating modes requested by the power controller
`define OPMODE_RUN 2'h0
`define OPMODE_SLEEP 2'h1
`define OPMODE_STOP 2'h2
`define OPMODE_STANDBY 2'h3
// Brownout option field
`define BOR_SEL_OFF 2'h0
`define BOR_SEL_LEVEL1 2'h1
`define BOR_SEL_LEVEL2 2'h2
`define BOR_SEL_LEVEL3 2'h3
`define BOR_SEL_RESET 2'h0
// Regulator configuration output encoding
`define REG_CFG_NORMAL 3'h0
`define REG_CFG_OVERDRIVE 3'h1
`define REG_CFG_UNDERDRIVE 3'h2
`define REG_CFG_POWERDOWN 3'h3
`define REG_CFG_OFF 3'h4
// Option byte load time after power-on threshold
`define OPT_LOAD_NS 400
`define CLK_PERIOD_NS 40
`define OPT_LOAD_CYCLES ((`OPT_LOAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: rtl/edge_event_detector.v
`timescale 1ns/1ps
module edge_event_detector (
  input wire mclk_in,
  input wire rst_in,
  input wire enable_in,
  input wire level_in,
  input wire rise_en_in,
  input wire fall_en_in,
  output reg event_out
);
  reg prev_r;
  reg armed_r;
  always @(posedge mclk_in) begin
    if (rst_in || !enable_in) begin
      prev_r <= 1'b0;
      armed_r <= 1'b0;
      event_out <= 1'b0;
    end else begin
      prev_r <= level_in;
      armed_r <= 1'b1;
      // First sample after enable only primes the history
      event_out <= armed_r && ((rise_en_in && level_in && !prev_r) || (fall_en_in && !level_in && prev_r));
    end
  end
endmodule

// file: tb/supply_supervisor_monitor.sv
`timescale 1ns/1ps
`include "supply_supervisor_map.vh"
module supply_supervisor_monitor (
  input wire mclk_in, rst_in, supervisor_enable_strap_in, bypass_strap_in, ext_reset_n_in, above_por_1v8_in,
  input wire above_2v1_in, pvd_enable_in, device_reset_out, supervisor_active_out, regulator_enabled_out,
  input wire programmable_voltage_detector_on_out, battery_backup_available_out,
  input wire [1:0] op_mode_in,
  input wire [2:0] regulator_cfg_out
);
  reg rst_d_r;
  always @(posedge mclk_in) rst_d_r <= rst_in;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in || rst_d_r);
  property p_por; $past(supervisor_enable_strap_in && !above_por_1v8_in) |-> device_reset_out; endproperty
  a_por: assert property (p_por) else $error("reset released below threshold");
  property p_ext; $past(!supervisor_enable_strap_in && !ext_reset_n_in) |-> device_reset_out; endproperty
  a_ext: assert property (p_ext) else $error("external reset ignored");
  property p_off; !supervisor_active_out |-> !programmable_voltage_detector_on_out && !battery_backup_available_out;
  endproperty
  a_off: assert property (p_off) else $error("feature alive with supervisor off");
  property p_pvd; $past(!pvd_enable_in) |-> !programmable_voltage_detector_on_out; endproperty
  a_pvd: assert property (p_pvd) else $error("detector on without enable");
  property p_byp; $past(bypass_strap_in) |-> !regulator_enabled_out && regulator_cfg_out == `REG_CFG_OFF; endproperty
  a_byp: assert property (p_byp) else $error("regulator on while bypassed");
  property p_od; regulator_cfg_out == `REG_CFG_OVERDRIVE |-> $past(above_2v1_in && op_mode_in < `OPMODE_STOP);
  endproperty
  a_od: assert property (p_od) else $error("illegal overdrive");
  property p_ud; regulator_cfg_out == `REG_CFG_UNDERDRIVE |-> $past(op_mode_in) == `OPMODE_STOP; endproperty
  a_ud: assert property (p_ud) else $error("underdrive outside stop");
  property p_pd; regulator_cfg_out == `REG_CFG_POWERDOWN |-> $past(op_mode_in) == `OPMODE_STANDBY; endproperty
  a_pd: assert property (p_pd) else $error("powerdown outside standby");
endmodule
bind supply_supervisor_regulator_modes supply_supervisor_monitor i_mon (.*);

// file: tb/ext_supervisor_model.sv
`timescale 1ns/1ps
module ext_supervisor_model (
  input wire above_1v7_in,
  output wire ext_reset_n_out
);
  assign ext_reset_n_out = above_1v7_in;
endmodule

// file: tb/supply_supervisor_regulator_modes_tb_top.sv
`timescale 1ns/1ps
`include "supply_supervisor_map.vh"
module supply_supervisor_regulator_modes_tb_top;
  reg mclk_in = 1'h0, rst_in = 1'h1, supervisor_enable_strap_in = 1'h1, bypass_strap_in = 1'h0, above_por_1v8_in = 1'h1;
  reg above_1v7_in = 1'h1, above_2v1_in = 1'h1, bor_above_level2_in = 1'h1, pvd_above_in = 1'h0, pvd_enable_in = 1'h0;
  reg pvd_rise_en_in = 1'h0, overdrive_req_in = 1'h0, underdrive_req_in = 1'h0, lp_regulator_req_in = 1'h0;
  reg pvd_fall_en_in = 1'h0;
  reg [1:0] op_mode_in = 2'h0, opt_bor_sel_in = 2'h2;
  wire bor_above_level1_in = 1'h1, bor_above_level3_in = 1'h1, opt_valid_in = 1'h1;
  wire ext_reset_n_in, device_reset_out, opt_loading_out, supervisor_active_out, programmable_voltage_detector_on_out;
  wire pvd_event_out, battery_backup_available_out, regulator_enabled_out, low_power_regulator_sel_out;
  wire request_refused_out;
  wire [1:0] bor_level_out;
  wire [2:0] regulator_cfg_out;
  localparam [80:0] ROWS = {9'h186, 9'h000, 9'h111, 9'h000, 9'h124, 9'h080, 9'h0C2, 9'h042, 9'h000};
  integer n_mismatch = 0, checked = 0, cycles = 0, i;
  reg [8:0] row;
  reg [2:0] n;
  supply_supervisor_regulator_modes i_dut (.*);
  ext_supervisor_model i_sup (.above_1v7_in(above_1v7_in), .ext_reset_n_out(ext_reset_n_in));
  initial forever #20 mclk_in = ~mclk_in;
  task chk(input [2:0] got, input [2:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(posedge mclk_in);
  endtask
  task boot;
    begin
      rst_in <= 1'h1;
      cyc(20);
      rst_in <= 1'h0;
      cyc(20);
    end
  endtask
  task end_of_test;
    begin
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  always @(posedge mclk_in) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      n_mismatch = n_mismatch + 1;
      end_of_test;
    end
  end
  initial begin
    boot;
    chk(device_reset_out, 1'h0);
    chk(supervisor_active_out, 1'h1);
    chk(bor_level_out, `BOR_SEL_LEVEL2);
    chk(programmable_voltage_detector_on_out, 1'h0);
    // Row layout: mode, overdrive, underdrive, low-power, expected cfg, expected low-power select
    for (i = 0; i < 9; i = i + 1) begin
      row = ROWS[i*9 +: 9];
      op_mode_in <= row[8:7];
      overdrive_req_in <= row[6];
      underdrive_req_in <= row[5];
      lp_regulator_req_in <= row[4];
      cyc(4);
      chk(regulator_cfg_out, row[3:1]);
      chk(low_power_regulator_sel_out, row[0]);
    end
    op_mode_in <= `OPMODE_RUN;
    boot;
    above_2v1_in <= 1'h0;
    overdrive_req_in <= 1'h1;
    cyc(4);
    chk(regulator_cfg_out, `REG_CFG_NORMAL);
    chk(request_refused_out, 1'h1);
    overdrive_req_in <= 1'h0;
    underdrive_req_in <= 1'h1;
    cyc(4);
    chk(regulator_cfg_out, `REG_CFG_NORMAL);
    pvd_enable_in <= 1'h1;
    pvd_rise_en_in <= 1'h1;
    cyc(4);
    chk(programmable_voltage_detector_on_out, 1'h1);
    pvd_above_in <= 1'h1;
    n = 3'h0;
    repeat (6) begin
      @(posedge mclk_in);
      n = n + pvd_event_out;
    end
    chk(n, 3'h1);
    pvd_fall_en_in <= 1'h1;
    pvd_above_in <= 1'h0;
    n = 3'h0;
    repeat (6) begin
      @(posedge mclk_in);
      n = n + pvd_event_out;
    end
    chk(n, 3'h1);
    bor_above_level2_in <= 1'h0;
    cyc(4);
    chk(device_reset_out, 1'h1);
    bor_above_level2_in <= 1'h1;
    above_por_1v8_in <= 1'h0;
    cyc(4);
    above_por_1v8_in <= 1'h1;
    cyc(4);
    chk(opt_loading_out, 1'h1);
    bypass_strap_in <= 1'h1;
    cyc(4);
    chk(regulator_enabled_out, 1'h0);
    bypass_strap_in <= 1'h0;
    supervisor_enable_strap_in <= 1'h0;
    boot;
    chk(battery_backup_available_out, 1'h0);
    chk(bor_level_out, `BOR_SEL_OFF);
    chk(device_reset_out, 1'h0);
    above_1v7_in <= 1'h0;
    cyc(4);
    chk(device_reset_out, 1'h1);
    end_of_test;
  end
endmodule
